// ==== sim/port_pin_config_ext_irq_tb.sv ====
// Self-checking bench for the port pin and external interrupt block.
`timescale 1ns/1ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); \
  fail_count++; end end

module port_pin_config_ext_irq_tb;
  import ppcx_pkg::*;

  // ****************************************
  // Signals and counters
  // ****************************************
  logic clk = 1'b0, sys_rst = 1'b1, strap = 1'b1, irs = 1'b1, xtal = 1'b0;
  logic irq0 = 1'b1, irq1 = 1'b1, it0 = 1'b0, it1 = 1'b1;
  logic idl = 1'b0, pd = 1'b0;
  logic [1:0] irq_en = 2'b00, ack = 2'b00;
  ppcx_wr_t reg_wr = '0;
  logic [17:0] ext_en = '0, ext_val = '0, pad, port_rd, schmitt_en;
  ppcx_drv_t [17:0] pin_drv;
  logic t0e, t1e, cke, f0, f1, wk, mc_tick;
  logic [3:0] v;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;
  // Expected {oe, strong high, weak, very weak} per mode and latch value.
  logic [3:0] exp_t [4][2] = '{'{4'b1000, 4'b0011}, '{4'b1000, 4'b1100},
                               '{4'b0000, 4'b0000}, '{4'b1000, 4'b0000}};

  // ****************************************
  // Clock, design and pad model
  // ****************************************
  initial begin
    forever #2.5 clk = ~clk;
  end

  ppcx_port DUT (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .port_reset_high_select(strap), .internal_reset_sel(irs),
    .crystal_osc_sel(xtal), .pin_in(pad), .ext_irq0_pin(irq0),
    .ext_irq1_pin(irq1), .ext_irq0_trigger_type(it0),
    .ext_irq1_trigger_type(it1), .irq_enable(irq_en),
    .irq_service_ack(ack), .power_down(pd), .idle(idl),
    .pin_drv(pin_drv), .port_rd(port_rd), .schmitt_en(schmitt_en),
    .t0_toggle_en(t0e), .t1_toggle_en(t1e), .clkout_en(cke),
    .ext_irq0_request_flag(f0), .ext_irq1_request_flag(f1),
    .wakeup_req(wk), .mc_tick(mc_tick));

  ppcx_pad_model pads (.clk(clk), .pin_drv(pin_drv), .ext_en(ext_en),
    .ext_val(ext_val), .pad(pad));

  // ****************************************
  // Access tasks
  // ****************************************

  // Waits k edges, then steps just past the last one.
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // One register write, taken at the next edge.
  task automatic wr(input ppcx_wsel_t s, input logic [7:0] d);
    reg_wr = '{en: 1'b1, sel: s, data: d};
    tick(1);
    reg_wr.en = 1'b0;
    // One idle edge keeps back-to-back calls from re-raising en at once.
    tick(1);
  endtask

  // Twelve-cycle reset with the chosen reset level strap.
  task automatic do_reset(input logic hi);
    strap = hi;
    sys_rst = 1'b1;
    tick(12);
    sys_rst = 1'b0;
  endtask

  // Steps to just after an interrupt sampling edge.
  task automatic sync();
    int k;
    k = 0;
    while (mc_tick !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    tick(1);
  endtask

  // Driver view of one pin, with the drive value hidden while off.
  function automatic logic [3:0] dv(input int i);
    return {pin_drv[i].oe, pin_drv[i].oe & pin_drv[i].o, pin_drv[i].wu,
            pin_drv[i].vu};
  endfunction

  // Prints the verdict and stops.
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    #1;
    do_reset(1'b1);
    tick(3);
    `CHK(dv(0), 4'b0011)
    `CHK(port_rd[7:0], 8'hFF)
    // An outside device pulls pin 0 low against the pull-ups.
    ext_en[0] = 1'b1;
    tick(3);
    `CHK(dv(0), 4'b0001)
    `CHK(port_rd[0], 1'b0)
    ext_en[0] = 1'b0;
    wr(PPCX_W_LATCH0, 8'hFE);
    tick(2);
    `CHK(dv(0), 4'b1000)
    // Count the clocks of strong drive after a rising latch.
    wr(PPCX_W_LATCH0, 8'hFF);
    n = 0;
    repeat (8) begin
      if (pin_drv[0].oe & pin_drv[0].o) n++;
      tick(1);
    end
    `CHK(n, 2)
    `CHK(dv(0), 4'b0011)
    // Every mode on pin 1 with both latch values; pin 0 stays quasi.
    for (int m = 0; m < 4; m++) begin
      wr(PPCX_W_MODEA0, {6'h00, m[1], 1'b0});
      wr(PPCX_W_MODEB0, {6'h00, m[0], 1'b0});
      for (int l = 0; l < 2; l++) begin
        wr(PPCX_W_LATCH0, {6'h3F, l[0], 1'b1});
        tick(4);
        v = dv(1);
        if (m == 1) `CHK(v[3:2], exp_t[m][l][3:2])
        else `CHK(v, exp_t[m][l])
        `CHK(dv(0), 4'b0011)
      end
    end
    // Input only still reads the pad.
    wr(PPCX_W_MODEA0, 8'h02);
    wr(PPCX_W_MODEB0, 8'h00);
    ext_en = 18'h32002;
    for (int b = 0; b < 2; b++) begin
      ext_val = {18{b[0]}};
      tick(3);
      `CHK(port_rd[1], b[0])
      `CHK(port_rd[16], b[0])
      `CHK(port_rd[13], b[0])
    end
    irs = 1'b0;
    xtal = 1'b1;
    // Fixed pins ignore a push-pull mode setting.
    wr(PPCX_W_MODEB1, 8'h0C);
    wr(PPCX_W_LATCH1, 8'hF3);
    tick(2);
    `CHK({dv(10), dv(11)}, 8'h88)
    `CHK({dv(13), dv(16), dv(17)}, 12'h000)
    `CHK({port_rd[17:16], port_rd[13]}, 3'b000)
    wr(PPCX_W_LATCH1, 8'hFF);
    ext_en = 18'h00000;
    tick(4);
    `CHK({dv(10), dv(11)}, 8'h00)
    // Misc bits of port 2: Schmitt selects, toggles and clock output.
    wr(PPCX_W_MODEA2, 8'hE4);
    tick(2);
    `CHK(schmitt_en, 18'h02CFF)
    `CHK({t0e, t1e, cke}, 3'b111)
    wr(PPCX_W_MODEA2, 8'h18);
    tick(2);
    `CHK(schmitt_en, 18'h3FF00)
    `CHK({t0e, t1e, cke}, 3'b000)
    // Level mode: one sample a machine cycle, no clear by service entry.
    sync();
    irq0 = 1'b0;
    tick(5);
    `CHK(f0, 1'b0)
    tick(1);
    `CHK(f0, 1'b1)
    ack = 2'b01;
    tick(1);
    ack = 2'b00;
    tick(6);
    `CHK(f0, 1'b1)
    irq_en = 2'b01;
    idl = 1'b1;
    tick(2);
    `CHK(wk, 1'b1)
    idl = 1'b0;
    pd = 1'b1;
    tick(2);
    `CHK(wk, 1'b1)
    irq_en = 2'b00;
    tick(2);
    `CHK(wk, 1'b0)
    pd = 1'b0;
    sync();
    irq0 = 1'b1;
    tick(6);
    `CHK(f0, 1'b0)
    // Edge mode: high then low sets, service entry clears.
    sync();
    irq1 = 1'b0;
    tick(6);
    `CHK(f1, 1'b1)
    tick(12);
    `CHK(f1, 1'b1)
    ack = 2'b10;
    tick(1);
    ack = 2'b00;
    tick(1);
    `CHK(f1, 1'b0)
    tick(12);
    `CHK(f1, 1'b0)
    irq1 = 1'b1;
    // Second reset with the low strap.
    do_reset(1'b0);
    tick(3);
    `CHK(dv(0), 4'b1000)
    print_verdict();
  end
endmodule

// ==== sim/ppcx_pad_model.sv ====
// Behavioural model of the external circuits that load the port pins.
`timescale 1ns/1ps

module ppcx_pad_model (
  input wire logic clk,
  input ppcx_pkg::ppcx_drv_t [17:0] pin_drv,
  input wire logic [17:0] ext_en,
  input wire logic [17:0] ext_val,
  output logic [17:0] pad
);
  import ppcx_pkg::*;

  // Level shown by a pad that nobody drives.
  logic [17:0] float_q = 18'h00000;

  // ****************************************
  // Pad resolution
  // ****************************************

  // A floating pad toggles every clock, so a stale level never passes.
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Strong drive wins, then the outside source, then the pull-ups.
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      if (pin_drv[i].oe) begin
        pad[i] = pin_drv[i].o;
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else if (pin_drv[i].wu | pin_drv[i].vu) begin
        pad[i] = 1'b1;
      end else begin
        pad[i] = float_q[i];
      end
    end
  end
endmodule

// ==== verilog/ppcx_consts.svh ====
// Constants for the port pin configuration and external interrupt block.
`ifndef PPCX_CONSTS_SVH
`define PPCX_CONSTS_SVH

// Number of pins: port 0 (8), port 1 (8), port 2 (2).
`define PPCX_NPIN 18
// CPU clocks in one machine cycle.
`define PPCX_MC_CLKS 6
// CPU clocks that the strong pull-up stays on.
`define PPCX_STRONG_CLKS 2
// Flat pin indices of the fixed-function and oscillator pins.
`define PPCX_IDX_P12 10
`define PPCX_IDX_P13 11
`define PPCX_IDX_P15 13
`define PPCX_IDX_P20 16
`define PPCX_IDX_P21 17
// Field positions in the port 2 mode and misc register.
`define PPCX_MISC_SCH0 2
`define PPCX_MISC_SCH1 3
`define PPCX_MISC_SCH2 4
`define PPCX_MISC_T0TOG 5
`define PPCX_MISC_T1TOG 6
`define PPCX_MISC_CLKOUT 7
// Reset values.
`define PPCX_LATCH_RST_HI 8'hFF
`define PPCX_LATCH_RST_LO 8'h00
`define PPCX_MODE_RST 8'h00
`define PPCX_IRQ_SAMP_RST 2'h3

`endif

// ==== verilog/ppcx_pkg.sv ====
// Types shared by the port pin configuration block.
package ppcx_pkg;

  // Output mode of one pin, coded as {mode_a bit, mode_b bit}.
  typedef enum logic [1:0] {
    PPCX_QUASI  = 2'b00,
    PPCX_PUSH   = 2'b01,
    PPCX_INONLY = 2'b10,
    PPCX_ODRAIN = 2'b11
  } ppcx_mode_t;

  // Target of a register write.
  typedef enum logic [3:0] {
    PPCX_W_LATCH0 = 4'h0,
    PPCX_W_LATCH1 = 4'h1,
    PPCX_W_LATCH2 = 4'h2,
    PPCX_W_MODEA0 = 4'h3,
    PPCX_W_MODEA1 = 4'h4,
    PPCX_W_MODEA2 = 4'h5,
    PPCX_W_MODEB0 = 4'h6,
    PPCX_W_MODEB1 = 4'h7,
    PPCX_W_MODEB2 = 4'h8
  } ppcx_wsel_t;

  // One register write strobe with its data.
  typedef struct packed {
    logic en;
    ppcx_wsel_t sel;
    logic [7:0] data;
  } ppcx_wr_t;

  // Driver controls of one pin: strong drive value and enable, weak and
  // very weak pull-ups.
  typedef struct packed {
    logic o;
    logic oe;
    logic wu;
    logic vu;
  } ppcx_drv_t;

endpackage

// ==== verilog/ppcx_port.sv ====
// Port pin mode, pull-up control and external interrupt sampling logic.
//
// Overview of operation
// - Trigger type 0: low sample requests interrupt.
// - Trigger type 1: high then low sets flag.
// - Sample interrupt pins once per machine cycle.
// - Edge flag clears on service entry.
// - Level flag tracks sampled pin, no clear.
// - Enabled interrupt in idle/power down wakes.
// - Mode bit pair selects pin output type.
// - Mode per bit; three pins fixed.
// - Standard pins default to quasi-bidirectional.
// - Very weak pull-up follows latch one.
// - Weak pull-up needs latch one, pin one.
// - Strong pull-up two clocks on latch rise.
// - Open drain: no pull-ups, pull-down on zero.
// - Push-pull: strong high on one, low zero.
// - P1.2, P1.3 fixed open drain outputs.
// - P1.5 Schmitt input only with internal reset.
// - Crystal option disables P2.0 and P2.1.
// - Reset level from config bit, quasi mode.
// - Schmitt select per port; fixed pins Schmitt.
// - Port 2 misc bits: Schmitt, toggles, clkout.
`timescale 1ns/1ps
`include "ppcx_consts.svh"

module ppcx_port (
  input wire logic clk,
  input wire logic sys_rst,
  input ppcx_pkg::ppcx_wr_t reg_wr,
  input wire logic port_reset_high_select,
  input wire logic internal_reset_sel,
  input wire logic crystal_osc_sel,
  input wire logic [17:0] pin_in,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic ext_irq0_trigger_type,
  input wire logic ext_irq1_trigger_type,
  input wire logic [1:0] irq_enable,
  input wire logic [1:0] irq_service_ack,
  input wire logic power_down,
  input wire logic idle,
  output ppcx_pkg::ppcx_drv_t [17:0] pin_drv,
  output logic [17:0] port_rd,
  output logic [17:0] schmitt_en,
  output logic t0_toggle_en,
  output logic t1_toggle_en,
  output logic clkout_en,
  output logic ext_irq0_request_flag,
  output logic ext_irq1_request_flag,
  output logic wakeup_req,
  output logic mc_tick
);
  import ppcx_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Effective mode of a pin, fixed-function pins overriding the bits.
  function automatic ppcx_mode_t eff_mode(input int idx, input logic a,
                                          input logic b);
    if (idx == `PPCX_IDX_P12 || idx == `PPCX_IDX_P13) begin
      return PPCX_ODRAIN;
    end else if (idx == `PPCX_IDX_P15) begin
      return PPCX_INONLY;
    end
    return ppcx_mode_t'({a, b});
  endfunction

  // True when the pin is usable as I/O at all.
  function automatic logic pin_ok(input int idx, input logic irst,
                                  input logic xtal);
    if (idx == `PPCX_IDX_P15) begin
      return irst;
    end else if (idx == `PPCX_IDX_P20 || idx == `PPCX_IDX_P21) begin
      return !xtal;
    end
    return 1'b1;
  endfunction

  // ****************************************************************
  // Machine cycle divider
  // ****************************************************************

  logic [2:0] mc_cnt_q; // CPU clock count within a machine cycle.
  logic mc_en; // One-cycle pulse, once per machine cycle.

  assign mc_en = (mc_cnt_q == 3'(`PPCX_MC_CLKS - 1));
  assign mc_tick = mc_en;

  // Counts CPU clocks and wraps after a whole machine cycle.
  always_ff @(posedge clk) begin
    if (sys_rst || mc_en) begin
      mc_cnt_q <= 3'h0;
    end else begin
      mc_cnt_q <= mc_cnt_q + 3'h1;
    end
  end

  // ****************************************************************
  // Port latches and mode registers
  // ****************************************************************

  logic [7:0] regs_q [0:8]; // Latches 0-2, mode a 0-2, mode b 0-2.
  logic [17:0] latch_v; // Output latch per flat pin index.
  logic [17:0] ma_v; // Mode a bit per pin.
  logic [17:0] mb_v; // Mode b bit per pin.

  assign latch_v = {regs_q[2][1:0], regs_q[1], regs_q[0]};
  assign ma_v = {regs_q[5][1:0], regs_q[4], regs_q[3]};
  assign mb_v = {regs_q[8][1:0], regs_q[7], regs_q[6]};

  // Loads the latches at reset from the strap and takes writes later.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 3; i++) begin
        // Reset level chosen by config bit, with quasi mode below.
        regs_q[i] <= port_reset_high_select ? `PPCX_LATCH_RST_HI
                                            : `PPCX_LATCH_RST_LO;
      end
      for (int i = 3; i < 9; i++) begin
        regs_q[i] <= `PPCX_MODE_RST;
      end
    end else if (reg_wr.en && reg_wr.sel <= PPCX_W_MODEB2) begin
      regs_q[reg_wr.sel] <= reg_wr.data;
    end
  end

  // Misc enables held in the upper bits of the port 2 mode a register.
  assign t0_toggle_en = regs_q[5][`PPCX_MISC_T0TOG];
  assign t1_toggle_en = regs_q[5][`PPCX_MISC_T1TOG];
  assign clkout_en = regs_q[5][`PPCX_MISC_CLKOUT];

  // ****************************************************************
  // Strong pull-up timers
  // ****************************************************************

  logic [17:0] latch_prev_q; // Latch value one clock ago.
  logic [1:0] strong_q [0:17]; // Remaining strong pull-up clocks.

  // Remembers the latches to find rising edges.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_prev_q <= '1;
    end else begin
      latch_prev_q <= latch_v;
    end
  end

  // Starts a two-clock strong pull-up on a quasi pin latch rise.
  always_ff @(posedge clk) begin
    for (int i = 0; i < `PPCX_NPIN; i++) begin
      if (sys_rst) begin
        strong_q[i] <= 2'h0;
      end else if (latch_v[i] && !latch_prev_q[i] &&
                   eff_mode(i, ma_v[i], mb_v[i]) == PPCX_QUASI) begin
        strong_q[i] <= 2'(`PPCX_STRONG_CLKS);
      end else if (strong_q[i] != 2'h0) begin
        strong_q[i] <= strong_q[i] - 2'h1;
      end
    end
  end

  // ****************************************************************
  // Pin drivers, input path and Schmitt selection
  // ****************************************************************

  ppcx_drv_t [17:0] drv_d; // Next driver controls.
  logic [17:0] rd_d; // Next read value.
  logic [17:0] sch_d; // Next Schmitt enables.

  // Works out every pin's drivers from its mode, latch and level.
  always_comb begin
    for (int i = 0; i < `PPCX_NPIN; i++) begin
      drv_d[i] = '0;
      case (eff_mode(i, ma_v[i], mb_v[i]))
        PPCX_QUASI: begin
          // Pull-down on zero, strong high only while timer runs.
          drv_d[i].vu = latch_v[i];
          drv_d[i].wu = latch_v[i] & pin_in[i];
          drv_d[i].oe = !latch_v[i] || strong_q[i] != 2'h0;
          drv_d[i].o = latch_v[i];
        end
        PPCX_PUSH: begin
          drv_d[i].oe = 1'b1;
          drv_d[i].o = latch_v[i];
        end
        PPCX_ODRAIN: begin
          drv_d[i].oe = !latch_v[i];
        end
        PPCX_INONLY: begin
          drv_d[i] = '0;
        end
        default: begin
          drv_d[i] = '0;
        end
      endcase
      // Disabled pins neither drive nor read.
      if (!pin_ok(i, internal_reset_sel, crystal_osc_sel)) begin
        drv_d[i] = '0;
      end
      rd_d[i] = pin_in[i] & pin_ok(i, internal_reset_sel,
                                   crystal_osc_sel);
      // Schmitt bit of the pin's port, forced for fixed pins.
      if (i < 8) begin
        sch_d[i] = regs_q[5][`PPCX_MISC_SCH0];
      end else if (i < 16) begin
        sch_d[i] = regs_q[5][`PPCX_MISC_SCH1];
      end else begin
        sch_d[i] = regs_q[5][`PPCX_MISC_SCH2];
      end
      if (i == `PPCX_IDX_P12 || i == `PPCX_IDX_P13 ||
          i == `PPCX_IDX_P15) begin
        sch_d[i] = 1'b1;
      end
    end
  end

  // Registers the pin controls so the pads see clean levels.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_drv <= '0;
      port_rd <= '0;
      schmitt_en <= '0;
    end else begin
      pin_drv <= drv_d;
      port_rd <= rd_d;
      schmitt_en <= sch_d;
    end
  end

  // ****************************************************************
  // External interrupt sampling and flags
  // ****************************************************************

  logic [1:0] irq_pin; // Both interrupt pins.
  logic [1:0] irq_trig; // Trigger type, 1 for edge.
  logic [1:0] samp_q; // Last machine-cycle sample of each pin.
  logic [1:0] flag_q; // Request flags.

  assign irq_pin = {ext_irq1_pin, ext_irq0_pin};
  assign irq_trig = {ext_irq1_trigger_type, ext_irq0_trigger_type};
  assign ext_irq0_request_flag = flag_q[0];
  assign ext_irq1_request_flag = flag_q[1];

  // Takes one sample of each pin per machine cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      samp_q <= `PPCX_IRQ_SAMP_RST;
    end else if (mc_en) begin
      samp_q <= irq_pin;
    end
  end

  // Updates each flag from the samples; a set beats a same-cycle ack.
  always_ff @(posedge clk) begin
    for (int n = 0; n < 2; n++) begin
      if (sys_rst) begin
        flag_q[n] <= 1'b0;
      end else if (!irq_trig[n]) begin
        // Level mode follows the new sample and ignores the ack.
        if (mc_en) begin
          flag_q[n] <= !irq_pin[n];
        end
      end else if (mc_en && samp_q[n] && !irq_pin[n]) begin
        flag_q[n] <= 1'b1;
      end else if (irq_service_ack[n]) begin
        flag_q[n] <= 1'b0;
      end
    end
  end

  // Raises a wakeup while asleep and an enabled request is pending.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeup_req <= 1'b0;
    end else begin
      wakeup_req <= (power_down || idle) &&
                    |(flag_q & irq_enable);
    end
  end

  // ****************************************************************
  // Assertions and cover points
  // ****************************************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic q0; // Pin 0 in quasi mode.
  logic st0; // Pin 0 strong high drive.
  assign q0 = !ma_v[0] && !mb_v[0];
  assign st0 = pin_drv[0].oe && pin_drv[0].o;

  a_mc_tick_period: assert property (
    mc_en |=> !mc_en [*5] ##1 mc_en)
    else $error("Machine cycle tick period is not six clocks.");
  a_samp_hold: assert property (
    !mc_en |=> $stable(samp_q))
    else $error("Interrupt sample changed off the machine cycle.");
  a_level_track: assert property (
    mc_en && !ext_irq0_trigger_type |=>
      ext_irq0_request_flag == !$past(ext_irq0_pin))
    else $error("Level flag does not follow the sampled pin.");
  a_edge_flag_set: assert property (
    mc_en && ext_irq1_trigger_type && samp_q[1] && !ext_irq1_pin
      |=> ext_irq1_request_flag)
    else $error("Edge flag not set on high then low samples.");
  a_edge_ack_clear: assert property (
    ext_irq1_trigger_type && irq_service_ack[1] &&
      !(mc_en && samp_q[1] && !ext_irq1_pin) |=> !ext_irq1_request_flag)
    else $error("Edge flag not cleared on service entry.");
  a_wake_req: assert property (
    (power_down || idle) && ext_irq0_request_flag && irq_enable[0]
      |=> wakeup_req)
    else $error("Enabled interrupt gave no wakeup request.");
  a_strong_pulse: assert property (
    $rose(latch_v[0]) ##0 (latch_v[0] && q0) [*3] |-> st0 ##1 st0)
    else $error("Strong pull-up not on for two clocks.");
  a_strong_off: assert property (
    (latch_v[0] && q0) [*5] |-> !st0)
    else $error("Strong pull-up stays on past two clocks.");
  a_weak_pullup: assert property (
    !$past(sys_rst) && $past(q0) |->
      pin_drv[0].wu == $past(latch_v[0] && pin_in[0]) &&
      pin_drv[0].vu == $past(latch_v[0]))
    else $error("Quasi pull-ups do not follow latch and pin.");
  a_push_pull: assert property (
    !$past(sys_rst) && $past(!ma_v[0] && mb_v[0]) |->
      pin_drv[0].oe && pin_drv[0].o == $past(latch_v[0]))
    else $error("Push-pull pin not driven to its latch.");
  a_input_only: assert property (
    $past(ma_v[0] && !mb_v[0]) |-> pin_drv[0] == '0)
    else $error("Input-only pin has a driver on.");
  a_fixed_od: assert property (
    !pin_drv[`PPCX_IDX_P12].o && !pin_drv[`PPCX_IDX_P12].wu &&
      !pin_drv[`PPCX_IDX_P12].vu)
    else $error("Fixed open-drain pin has a pull-up on.");
  a_xtal_off: assert property (
    $past(crystal_osc_sel) |->
      pin_drv[`PPCX_IDX_P20] == '0 && !port_rd[`PPCX_IDX_P20])
    else $error("Oscillator pin active with crystal selected.");

  c_edge_irq: cover property (
    ext_irq0_trigger_type && !ext_irq0_request_flag ##1
      ext_irq0_request_flag);
  c_level_irq: cover property (
    !ext_irq1_trigger_type && ext_irq1_request_flag);
  c_wake: cover property (power_down && wakeup_req);
  c_strong: cover property (q0 && st0 && latch_v[0]);

endmodule
